// >>> hw/epcu_regs.vh
// epcu_regs.vh: register offsets, field positions and constants for the
// event performance counter unit.
// assumes: included by every design file of the block except the synchroniser, by bare name.
//
// Functional notes
// - four counter pairs, numbered four to seven, each select plus count.
// - select register picks the event and its qualifying conditions.
// - count register holds the running tally of its pair.
// - register writes accepted only at privilege level zero.
// - monitor bit in select register marks counter privileged or user.
// - privileged reads need level zero; user reads blocked by secure bit except at level zero.
// - user counters counted only while user monitor enable is set.
// - privileged counters counted only while privileged enable is set.
// - freeze control bit zero stops all counters; one lets them count.
// - each counter may raise an overflow interrupt.
// - privileged counter counts in all contexts while both enables set.
`ifndef EPCU_REGS_VH
`define EPCU_REGS_VH

// address map: word index on an 8-bit address
`define EPCU_ADDR_W        8
`define EPCU_DATA_W        32
`define EPCU_CNT_W         32
`define EPCU_EVT_W         8
`define EPCU_NUM_CNT       4
`define EPCU_FIRST_PAIR    4
`define EPCU_GLOBAL_CTL    8'h00
`define EPCU_OVF_STATUS    8'h01
`define EPCU_OVF_MASK      8'h02
`define EPCU_ACCESS_ERR    8'h03
`define EPCU_SEL_BASE      8'h04
`define EPCU_CNT_BASE      8'h14
`define EPCU_PAIR_MASK     8'hfc

// global control: freeze control bit
`define EPCU_FREEZE_BIT    0

// event select layout
`define EPCU_SEL_EVT_LSB   0
`define EPCU_SEL_EVT_MSB   7
`define EPCU_SEL_PM_BIT    8
`define EPCU_SEL_OVIE_BIT  9
`define EPCU_SEL_USED_W    10
`define EPCU_SEL_RESET     10'h000

// privilege level field
`define EPCU_CPL_W         2
`define EPCU_CPL_PRIV      2'h0

// access error flags
`define EPCU_ERR_WRITE     0
`define EPCU_ERR_READ      1

`define EPCU_ZERO32        32'h0000_0000
`define EPCU_ONE_CNT       32'h0000_0001

`endif

// >>> hw/epcu_sync.v
// epcu_sync.v: two-stage synchroniser for a bus of level signals.
// assumes: inputs arrive from outside the clk domain.
`timescale 1ns/1ps
module epcu_sync
#(
   parameter W = 1
)
(
   input  wire         clk,
   input  wire         reset,
   input  wire [W-1:0] async_in,
   output reg  [W-1:0] sync_out
);

   reg [W-1:0] stage1;

   // first stage feeds only the second
   always @(posedge clk)
   begin
      if (reset)
      begin
         stage1   <= {W{1'b0}};
         sync_out <= {W{1'b0}};
      end
      else
      begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end

endmodule

// >>> hw/epcu_counter.v
// epcu_counter.v: one generic counter pair, select plus count.
// assumes: gating terms and writes come from the clk domain.
`timescale 1ns/1ps
`include "epcu_regs.vh"
module epcu_counter
(
   input  wire                       clk,
   input  wire                       reset,
   input  wire                       sel_wr,
   input  wire                       cnt_wr,
   input  wire [`EPCU_DATA_W-1:0]    wdata,
   input  wire [`EPCU_NUM_CNT*2-1:0] events,
   input  wire                       freeze_on,
   input  wire                       priv_en,
   input  wire                       user_en,
   output reg  [`EPCU_SEL_USED_W-1:0] sel,
   output reg  [`EPCU_CNT_W-1:0]     count,
   output wire                       ovf_pulse
);

   wire [`EPCU_EVT_W-1:0] evt_code;
   wire                   pm;
   wire                   evt_hit;
   wire                   enabled;
   wire                   inc;

   assign evt_code = sel[`EPCU_SEL_EVT_MSB:`EPCU_SEL_EVT_LSB];
   assign pm       = sel[`EPCU_SEL_PM_BIT];
   // codes past the event bus select nothing
   assign evt_hit  = (evt_code < (`EPCU_NUM_CNT * 2)) ?
                     events[evt_code[2:0]] : 1'b0;
   assign enabled  = pm ? priv_en : user_en;
   assign inc      = freeze_on & enabled & evt_hit;
   // overflow flagged only if this counter asks for the interrupt
   assign ovf_pulse = inc & (&count) & sel[`EPCU_SEL_OVIE_BIT];

   // select register
   always @(posedge clk)
   begin
      if (reset)
         sel <= `EPCU_SEL_RESET;
      else if (sel_wr)
         sel <= wdata[`EPCU_SEL_USED_W-1:0];
   end

   // count register; a write wins over a count in the same cycle
   always @(posedge clk)
   begin
      if (reset)
         count <= `EPCU_ZERO32;
      else if (cnt_wr)
         count <= wdata;
      else if (inc)
         count <= count + `EPCU_ONE_CNT; // wraps to zero
   end

endmodule

// >>> hw/epcu_top.v
// epcu_top.v: event performance counter unit, four counter pairs,
// overflow status and mask, privilege checks on every write and on pair register reads.
// assumes: register port and events on clk; status word bits come from
// the processor pipeline and are synchronised here.
//
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "epcu_regs.vh"
module epcu_top
(
   input  wire                       clk,
   input  wire                       reset,
   input  wire [`EPCU_ADDR_W-1:0]    addr,
   input  wire [`EPCU_DATA_W-1:0]    wdata,
   input  wire                       wr,
   input  wire                       rd,
   output reg  [`EPCU_DATA_W-1:0]    rdata,
   input  wire [`EPCU_CPL_W-1:0]     current_privilege_level,
   input  wire                       secure_counter_read_bit,
   input  wire                       user_monitor_enable,
   input  wire                       priv_monitor_enable,
   input  wire                       default_priv_monitor_enable,
   input  wire [`EPCU_NUM_CNT*2-1:0] events,
   output wire                       irq
);

   // status word bits pass a synchroniser before any use
   wire [`EPCU_CPL_W+3:0] psw_raw;
   wire [`EPCU_CPL_W+3:0] psw_sync;
   wire [`EPCU_CPL_W-1:0] cpl_s;
   wire                   sp_s;
   wire                   up_s;
   wire                   pp_s;
   wire                   dpp_s;

   assign psw_raw = {current_privilege_level, secure_counter_read_bit,
                     user_monitor_enable, priv_monitor_enable,
                     default_priv_monitor_enable};

   epcu_sync #(.W(`EPCU_CPL_W + 4)) u_psw_sync
   (
      .clk      (clk),
      .reset    (reset),
      .async_in (psw_raw),
      .sync_out (psw_sync)
   );

   assign cpl_s = psw_sync[`EPCU_CPL_W+3:4];
   assign sp_s  = psw_sync[3];
   assign up_s  = psw_sync[2];
   assign pp_s  = psw_sync[1];
   assign dpp_s = psw_sync[0];

   // control and status registers
   reg                      freeze_control_bit;
   reg [`EPCU_NUM_CNT-1:0]  ovf_status;
   reg [`EPCU_NUM_CNT-1:0]  ovf_mask;
   reg [1:0]                access_err;

   wire                     is_priv;
   wire                     wr_ok;
   wire                     priv_en;
   wire                     user_en;

   assign is_priv = (cpl_s == `EPCU_CPL_PRIV);
   assign wr_ok   = wr & is_priv;
   // privileged counting needs both enables, so it spans all contexts
   assign priv_en = pp_s & dpp_s;
   assign user_en = up_s;

   // address decode for the pair registers
   wire                     in_sel;
   wire                     in_cnt;
   wire [1:0]               pair_idx;

   assign in_sel   = ((addr & `EPCU_PAIR_MASK) == `EPCU_SEL_BASE);
   assign in_cnt   = ((addr & `EPCU_PAIR_MASK) == `EPCU_CNT_BASE);
   assign pair_idx = addr[1:0];

   // per-pair outputs
   wire [`EPCU_SEL_USED_W*`EPCU_NUM_CNT-1:0] sel_all;
   wire [`EPCU_CNT_W*`EPCU_NUM_CNT-1:0]      cnt_all;
   wire [`EPCU_NUM_CNT-1:0]                  ovf_pulse;

   genvar g;
   generate
      for (g = 0; g < `EPCU_NUM_CNT; g = g + 1)
      begin : pair
         // pairs carry the numbers four to seven in software's view
         epcu_counter u_cnt
         (
            .clk       (clk),
            .reset     (reset),
            .sel_wr    (wr_ok & in_sel & (pair_idx == g)),
            .cnt_wr    (wr_ok & in_cnt & (pair_idx == g)),
            .wdata     (wdata),
            .events    (events),
            .freeze_on (freeze_control_bit),
            .priv_en   (priv_en),
            .user_en   (user_en),
            .sel       (sel_all[g*`EPCU_SEL_USED_W +: `EPCU_SEL_USED_W]),
            .count     (cnt_all[g*`EPCU_CNT_W +: `EPCU_CNT_W]),
            .ovf_pulse (ovf_pulse[g])
         );
      end
   endgenerate

   // selected pair fields for reads
   wire [`EPCU_SEL_USED_W-1:0] sel_pick;
   wire [`EPCU_CNT_W-1:0]      cnt_pick;
   wire                        pick_pm;
   wire                        cnt_rd_ok;

   assign sel_pick = sel_all[pair_idx*`EPCU_SEL_USED_W +: `EPCU_SEL_USED_W];
   assign cnt_pick = cnt_all[pair_idx*`EPCU_CNT_W +: `EPCU_CNT_W];
   assign pick_pm  = sel_pick[`EPCU_SEL_PM_BIT];
   // privileged count only at level zero; user count at level zero or unless secured
   assign cnt_rd_ok = is_priv | (~pick_pm & ~sp_s);

   // global control and interrupt registers
   always @(posedge clk)
   begin
      if (reset)
      begin
         freeze_control_bit <= 1'b0;
         ovf_mask           <= {`EPCU_NUM_CNT{1'b0}};
      end
      else if (wr_ok)
      begin
         if (addr == `EPCU_GLOBAL_CTL)
            freeze_control_bit <= wdata[`EPCU_FREEZE_BIT];
         if (addr == `EPCU_OVF_MASK)
            ovf_mask <= wdata[`EPCU_NUM_CNT-1:0];
      end
   end

   // sticky overflow flags; a new overflow beats a clear
   always @(posedge clk)
   begin
      if (reset)
         ovf_status <= {`EPCU_NUM_CNT{1'b0}};
      else if (wr_ok && addr == `EPCU_OVF_STATUS)
         ovf_status <= (ovf_status & ~wdata[`EPCU_NUM_CNT-1:0])
                       | ovf_pulse;
      else
         ovf_status <= ovf_status | ovf_pulse;
   end

   // refused writes and refused count reads are recorded so software can see them
   wire wr_refused;
   wire rd_refused;

   assign wr_refused = wr & ~is_priv;
   assign rd_refused = rd & in_cnt & ~cnt_rd_ok;

   always @(posedge clk)
   begin
      if (reset)
         access_err <= 2'h0;
      else if (wr_ok && addr == `EPCU_ACCESS_ERR)
         access_err <= (access_err & ~wdata[1:0])
                       | {rd_refused, wr_refused};
      else
         access_err <= access_err | {rd_refused, wr_refused};
   end

   // read data, one cycle after the strobe, zero otherwise
   reg [`EPCU_DATA_W-1:0] next_rdata;

   always @*
   begin
      next_rdata = `EPCU_ZERO32;
      if (rd)
      begin
         if (in_cnt)
         begin
            if (cnt_rd_ok)
               next_rdata = cnt_pick;
         end
         else if (in_sel)
         begin
            // select reads are privileged only
            if (is_priv)
               next_rdata[`EPCU_SEL_USED_W-1:0] = sel_pick;
         end
         else
         begin
            case (addr)
               `EPCU_GLOBAL_CTL:
                  next_rdata[`EPCU_FREEZE_BIT] = freeze_control_bit;
               `EPCU_OVF_STATUS:
                  next_rdata[`EPCU_NUM_CNT-1:0] = ovf_status;
               `EPCU_OVF_MASK:
                  next_rdata[`EPCU_NUM_CNT-1:0] = ovf_mask;
               `EPCU_ACCESS_ERR:
                  next_rdata[1:0] = access_err;
               default:
                  next_rdata = `EPCU_ZERO32;
            endcase
         end
      end
   end

   always @(posedge clk)
   begin
      if (reset)
         rdata <= `EPCU_ZERO32;
      else
         rdata <= next_rdata;
   end

   // level interrupt while any unmasked flag stands
   assign irq = |(ovf_status & ovf_mask);

endmodule

// >>> verif/epcu_checker.sv
// epcu_checker.sv: port-level assertions for the event counter unit.
// assumes: bound to epcu_top, sees its ports only.
`timescale 1ns/1ps
`include "epcu_regs.vh"
module epcu_checker
(
   input logic                    clk,
   input logic                    reset,
   input logic [`EPCU_ADDR_W-1:0] addr,
   input logic [`EPCU_DATA_W-1:0] wdata,
   input logic                    wr,
   input logic                    rd,
   input logic [`EPCU_DATA_W-1:0] rdata,
   input logic [`EPCU_CPL_W-1:0]  current_privilege_level,
   input logic                    irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // level must sit still past the synchroniser before it counts
   logic [2:0] zero_hist;
   always @(posedge clk)
      zero_hist <= {zero_hist[1:0], current_privilege_level == 2'h0};
   wire lvl0 = &zero_hist && current_privilege_level == 2'h0;
   wire lvl3 = ~|zero_hist && current_privilege_level != 2'h0;
   wire sel_hit = addr[7:2] == 6'h01;
   wire unmapped = (addr >= 8'h08 && addr < 8'h14) || addr >= 8'h18;

   a_rdata_idle: assert property (!rd |=> rdata == 32'h0)
      else $error("read data not zero outside a read");
   a_reset_quiet: assert property ($fell(reset) |-> rdata == 32'h0 && !irq)
      else $error("outputs not quiet after reset");
   a_unmapped_zero: assert property (rd && unmapped |=> rdata == 32'h0)
      else $error("unmapped read not zero");
   a_sel_guard: assert property (rd && sel_hit && lvl3 |=> rdata == 32'h0)
      else $error("select read leaked at user level");
   a_sel_width: assert property (rd && sel_hit |=> rdata[31:10] == 22'h0)
      else $error("select read upper bits set");
   a_ovf_width: assert property (rd && addr inside {8'h01, 8'h02}
      |=> rdata[31:4] == 28'h0) else $error("flag read too wide");
   a_err_width: assert property (rd && addr == 8'h03 |=> rdata[31:2] == 30'h0)
      else $error("error read too wide");
   a_ctl_width: assert property (rd && addr == 8'h00 |=> rdata[31:1] == 31'h0)
      else $error("control read too wide");
   a_irq_masked: assert property (wr && addr == 8'h02 && wdata[3:0] == 4'h0
      && lvl0 |=> !irq) else $error("irq high with all masked");

   c_user_read: cover property (rd && sel_hit && lvl3);
   c_irq_rise: cover property ($rose(irq));
   c_user_write: cover property (wr && lvl3);
endmodule

// >>> verif/epcu_top_tb_top.sv
// epcu_top_tb_top.sv: self-checking bench for the event counter unit.
// assumes: design files and epcu_checker.sv compiled first.
`timescale 1ns/1ps
module epcu_top_tb_top;
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic [1:0]  cpl = 2'h0;
   logic [3:0]  psw = 4'h0; // secure, user, priv, default priv
   logic [7:0]  events = 8'h00;
   logic        irq;
   int          error_cnt = 0;
   int          cmp_count = 0;

   // 100 MHz
   always #5 clk = ~clk;

   epcu_top dut
   (
      .clk                        (clk),
      .reset                      (reset),
      .addr                       (addr),
      .wdata                      (wdata),
      .wr                         (wr),
      .rd                         (rd),
      .rdata                      (rdata),
      .current_privilege_level    (cpl),
      .secure_counter_read_bit    (psw[3]),
      .user_monitor_enable        (psw[2]),
      .priv_monitor_enable        (psw[1]),
      .default_priv_monitor_enable(psw[0]),
      .events                     (events),
      .irq                        (irq)
   );

   task automatic check(input string n, input logic [31:0] seen,
                        input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED %s @%h expected %h seen %h", n, addr, exp,
                  seen);
      end
   endtask

   // one-cycle strobes, a free cycle before each
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 check("rdata", rdata, exp);
   endtask

   // status inputs need two edges to pass the synchroniser; the task waits three
   task automatic set_psw(input logic [1:0] c, input logic [3:0] p);
      @(posedge clk);
      cpl <= c;
      psw <= p;
      repeat (3) @(posedge clk);
   endtask

   task automatic burst(input int n, input logic [7:0] m);
      @(posedge clk);
      events <= m;
      repeat (n) @(posedge clk);
      events <= 8'h00;
   endtask

   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // watchdog: the sequence needs well under a thousand cycles
   initial
   begin
      repeat (5000) @(posedge clk);
      error_cnt++;
      end_of_test();
   end

   initial
   begin
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      repeat (3) @(posedge clk);
      rd_chk(8'h00, 32'h0);
      rd_chk(8'h01, 32'h0);
      rd_chk(8'h14, 32'h0);
      $display("test reset done");
      for (int i = 0; i < 4; i++)
      begin
         wr_reg(8'h04 + 8'(i), 32'hffff_fd00 | i);
         wr_reg(8'h14 + 8'(i), 32'ha5a5_0000 | i);
         rd_chk(8'h04 + 8'(i), 32'h0000_0100 | i);
         rd_chk(8'h14 + 8'(i), 32'ha5a5_0000 | i);
      end
      wr_reg(8'h10, 32'h1);
      rd_chk(8'h10, 32'h0);
      $display("test map done");
      set_psw(2'h3, 4'h0);
      wr_reg(8'h14, 32'h77);
      wr_reg(8'h00, 32'h1);
      set_psw(2'h0, 4'h0);
      rd_chk(8'h14, 32'ha5a5_0000);
      rd_chk(8'h00, 32'h0);
      rd_chk(8'h03, 32'h1);
      wr_reg(8'h03, 32'h1);
      rd_chk(8'h03, 32'h0);
      $display("test write guard done");
      wr_reg(8'h05, 32'h1);
      set_psw(2'h3, 4'h0);
      rd_chk(8'h04, 32'h0);
      rd_chk(8'h14, 32'h0);
      rd_chk(8'h15, 32'ha5a5_0001);
      set_psw(2'h3, 4'h8);
      rd_chk(8'h15, 32'h0);
      set_psw(2'h0, 4'h0);
      rd_chk(8'h03, 32'h2);
      $display("test read guard done");
      wr_reg(8'h14, 32'h0);
      wr_reg(8'h15, 32'h0);
      wr_reg(8'h06, 32'h202);
      wr_reg(8'h16, 32'hffff_fffe);
      set_psw(2'h0, 4'h7);
      burst(4, 8'h0f);
      rd_chk(8'h14, 32'h0);
      rd_chk(8'h16, 32'hffff_fffe);
      wr_reg(8'h00, 32'h1);
      set_psw(2'h0, 4'h3);
      burst(10, 8'h03);
      rd_chk(8'h14, 32'd10);
      rd_chk(8'h15, 32'h0);
      set_psw(2'h0, 4'h5);
      burst(5, 8'h03);
      rd_chk(8'h14, 32'd10);
      rd_chk(8'h15, 32'd5);
      set_psw(2'h0, 4'h2);
      burst(3, 8'h03);
      rd_chk(8'h14, 32'd10);
      $display("test counting done");
      set_psw(2'h0, 4'h4);
      wr_reg(8'h02, 32'h4);
      burst(2, 8'h04);
      #1 check("irq", 32'(irq), 32'h1);
      rd_chk(8'h16, 32'h0);
      rd_chk(8'h01, 32'h4);
      wr_reg(8'h02, 32'h0);
      #1 check("irq", 32'(irq), 32'h0);
      wr_reg(8'h02, 32'h4);
      #1 check("irq", 32'(irq), 32'h1);
      wr_reg(8'h01, 32'h4);
      #1 check("irq", 32'(irq), 32'h0);
      $display("test overflow done");
      end_of_test();
   end
endmodule

bind epcu_top epcu_checker u_chk
(
   .clk(clk),
   .reset(reset),
   .addr(addr),
   .wdata(wdata),
   .wr(wr),
   .rd(rd),
   .rdata(rdata),
   .current_privilege_level(current_privilege_level),
   .irq(irq)
);
